/* core/gcr_pkg.sv */
// Package: global configuration register constants and carrier types
package gcr_pkg;

  // ----------------------------------------------------------------
  // Access format
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int WRITE_FLAG_POS = 7;               // Address plus 0x80 marks a write
  localparam logic [ADDR_W-1:0] WRITE_OFFSET = 8'h80;
  localparam logic [6:0] ADDR_GLOBAL_CONFIGURATION = 7'h00;

  // ----------------------------------------------------------------
  // Register layout
  // ----------------------------------------------------------------
  localparam int CFG_BITS = 12;
  localparam logic [CFG_BITS-1:0] CFG_RESET = 12'h000;
  localparam int POS_PARALLELED_OUTPUTS = 0;
  localparam int POS_EXT_PULSE_CTRL_AXIS1 = 1;
  localparam int POS_EXT_PULSE_CTRL_AXIS2 = 2;
  localparam int POS_COMPARE_IRQ_ON_SHARED = 3;
  localparam int POS_ENCODER1_INDEX_SOURCE = 4;
  localparam int POS_ENCODER2_ON_RIGHT_REFS = 5;
  localparam int POS_ENCODER2_INDEX_SOURCE = 6;
  localparam int POS_TEST_MODE = 7;
  localparam int POS_REVERSE_AXIS1 = 8;
  localparam int POS_REVERSE_AXIS2 = 9;
  localparam int POS_WRITE_LOCK = 10;
  localparam int POS_LOAD_SPEED_COUPLING = 11;

  localparam int NUM_AXES = 2;
  localparam int DRV_CTRL_W = 8;
  localparam int TEST_SEL_W = 3;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic load_speed_coupling;
    logic write_lock;
    logic reverse_axis2;
    logic reverse_axis1;
    logic test_mode;
    logic encoder2_index_source;
    logic encoder2_on_right_refs;
    logic encoder1_index_source;
    logic compare_irq_on_shared;
    logic ext_pulse_ctrl_axis2;
    logic ext_pulse_ctrl_axis1;
    logic paralleled_outputs;
  } gcr_cfg_t;

  typedef struct packed {
    logic pulse;
    logic direction;
  } gcr_motion_t;

  typedef struct packed {
    logic a;
    logic b;
    logic n;
  } gcr_encoder_t;

endpackage

/* core/gcr_axis_route.sv */
// Per-axis motion source selection and direction inversion
module gcr_axis_route
  import gcr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Configuration
  input wire logic ext_ctrl_i,
  input wire logic reverse_i,
  // Motion sources
  input wire gcr_motion_t ramp_i,
  input wire gcr_motion_t ext_i,
  // Routed motion
  output gcr_motion_t motion_o,
  output logic ramp_in_use_o
);

  // ----------------------------------------------------------------
  // Source pick and inversion
  // ----------------------------------------------------------------
  gcr_motion_t motion_next;

  // External pulse/direction replaces the ramp generator when selected
  always_comb begin
    motion_next = ext_ctrl_i ? ext_i : ramp_i;
    motion_next.direction = motion_next.direction ^ reverse_i;
  end

  // Registered so the driver sees glitch-free step edges
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      motion_o <= '0;
      ramp_in_use_o <= 1'b0;
    end else begin
      motion_o <= motion_next;
      ramp_in_use_o <= ~ext_ctrl_i;
    end
  end

endmodule

/* core/gcr_top.sv */
// Global configuration register with pin routing and axis control
module gcr_top
  import gcr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Decoded register access from the serial interface
  input wire logic acc_valid_i,
  input wire logic [ADDR_W-1:0] acc_addr_i,
  input wire logic [DATA_W-1:0] acc_wdata_i,
  output logic acc_ready_o,
  output logic [DATA_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic wr_ignored_o,
  output logic [CFG_BITS-1:0] cfg_o,
  // Interface selection
  input wire logic interface_select_i,
  output logic uart_mode_o,
  // Motion sources
  input wire logic [NUM_AXES-1:0] ramp_pulse_i,
  input wire logic [NUM_AXES-1:0] ramp_dir_i,
  input wire logic pulse_in_axis1_i,
  input wire logic direction_in_axis1_i,
  input wire logic pulse_in_axis2_i,
  input wire logic direction_in_axis2_i,
  // Driver side
  input wire logic [DRV_CTRL_W-1:0] drv_ctrl_axis1_i,
  input wire logic [DRV_CTRL_W-1:0] drv_ctrl_axis2_i,
  output logic [NUM_AXES-1:0] drv_pulse_o,
  output logic [NUM_AXES-1:0] drv_dir_o,
  output logic [DRV_CTRL_W-1:0] drv_ctrl_axis1_o,
  output logic [DRV_CTRL_W-1:0] drv_ctrl_axis2_o,
  output logic [NUM_AXES-1:0] ramp_in_use_o,
  // Reference switch and serial pins
  input wire logic left_switch_axis1_i,
  input wire logic left_switch_axis2_i,
  input wire logic right_switch_axis1_i,
  input wire logic right_switch_axis2_i,
  output logic right_switch_axis2_o,
  output logic right_switch_axis2_oe_o,
  input wire logic serial_line_true_i,
  input wire logic serial_line_inverted_i,
  input wire logic gp_pin_0_i,
  input wire logic gp_pin_1_i,
  // Shared encoder 1 A/B pins
  input wire logic shared_pin_a_i,
  input wire logic shared_pin_b_i,
  output logic shared_pin_a_o,
  output logic shared_pin_a_oe_o,
  output logic shared_pin_b_o,
  output logic shared_pin_b_oe_o,
  // Compare pulse, interrupt and test sources
  input wire logic compare_pulse_out_i,
  input wire logic irq_src_i,
  input wire logic [TEST_SEL_W-1:0] node_address_field_i,
  input wire logic test_level_i,
  output logic [TEST_SEL_W-1:0] test_sel_o,
  // Encoder and switch results
  output gcr_encoder_t encoder1_o,
  output gcr_encoder_t encoder2_o,
  output logic encoder1_in_use_o,
  output logic [NUM_AXES-1:0] right_switch_o,
  output logic right_switch_valid_o,
  // Load speed control
  input wire logic [NUM_AXES-1:0] load_speed_mode_i,
  input wire logic [NUM_AXES-1:0] load_slow_i,
  output logic [NUM_AXES-1:0] load_hold_o
);

  // ----------------------------------------------------------------
  // Register access decode
  // ----------------------------------------------------------------
  gcr_cfg_t cfg_reg;
  gcr_cfg_t cfg_next;
  logic is_write;
  logic hits_cfg;
  logic wr_take;
  logic wr_block;

  // Address bit 7 carries the write flag, the low bits the register
  assign is_write = acc_addr_i[WRITE_FLAG_POS];
  assign hits_cfg = (acc_addr_i[WRITE_FLAG_POS-1:0] == ADDR_GLOBAL_CONFIGURATION);
  assign wr_block = cfg_reg.write_lock;
  assign wr_take = acc_valid_i && is_write && hits_cfg && !wr_block;

  // Every access is taken at once; no back-pressure needed for one register
  assign acc_ready_o = 1'b1;

  // Next register value from the write data
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_take) begin
      cfg_next = gcr_cfg_t'(acc_wdata_i[CFG_BITS-1:0]);
    end
  end

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  // Only reset can release the lock; there is no unlock write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_reg <= gcr_cfg_t'(CFG_RESET);
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign cfg_o = cfg_reg;

  // ----------------------------------------------------------------
  // Read answer
  // ----------------------------------------------------------------
  // Addresses outside this register answer zero; other banks live elsewhere
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= '0;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= acc_valid_i && !is_write;
      if (acc_valid_i && !is_write) begin
        rd_data_o <= hits_cfg ? {{(DATA_W-CFG_BITS){1'b0}}, cfg_reg} : '0;
      end
    end
  end

  // One-cycle flag for a write dropped by the lock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ignored_o <= 1'b0;
    end else begin
      wr_ignored_o <= acc_valid_i && is_write && hits_cfg && wr_block;
    end
  end

  // ----------------------------------------------------------------
  // Interface mode
  // ----------------------------------------------------------------
  // Select pin is sampled each cycle so the serial block sees a clean level
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      uart_mode_o <= 1'b0;
    end else begin
      uart_mode_o <= interface_select_i;
    end
  end

  // ----------------------------------------------------------------
  // Axis motion routing
  // ----------------------------------------------------------------
  gcr_motion_t ramp_src [NUM_AXES];
  gcr_motion_t ext_src [NUM_AXES];
  gcr_motion_t routed [NUM_AXES];
  logic [NUM_AXES-1:0] ext_sel;
  logic [NUM_AXES-1:0] rev_sel;

  assign ext_sel = {cfg_reg.ext_pulse_ctrl_axis2, cfg_reg.ext_pulse_ctrl_axis1};
  assign rev_sel = {cfg_reg.reverse_axis2, cfg_reg.reverse_axis1};
  assign ext_src[0] = '{pulse: pulse_in_axis1_i, direction: direction_in_axis1_i};
  assign ext_src[1] = '{pulse: pulse_in_axis2_i, direction: direction_in_axis2_i};

  // One routing slice per axis
  generate
    for (genvar ax = 0; ax < NUM_AXES; ax++) begin : g_axis
      assign ramp_src[ax] = '{pulse: ramp_pulse_i[ax], direction: ramp_dir_i[ax]};
      gcr_axis_route u_route (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ext_ctrl_i(ext_sel[ax]),
        .reverse_i(rev_sel[ax]),
        .ramp_i(ramp_src[ax]),
        .ext_i(ext_src[ax]),
        .motion_o(routed[ax]),
        .ramp_in_use_o(ramp_in_use_o[ax])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Driver outputs and paralleled mode
  // ----------------------------------------------------------------
  // In paralleled mode driver 2 mirrors driver 1 and its own inputs are dropped
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drv_pulse_o <= '0;
      drv_dir_o <= '0;
    end else begin
      drv_pulse_o[0] <= routed[0].pulse;
      drv_dir_o[0] <= routed[0].direction;
      drv_pulse_o[1] <= cfg_reg.paralleled_outputs ? routed[0].pulse : routed[1].pulse;
      drv_dir_o[1] <= cfg_reg.paralleled_outputs ? routed[0].direction : routed[1].direction;
    end
  end

  // Driver control words follow the same mirroring
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drv_ctrl_axis1_o <= '0;
      drv_ctrl_axis2_o <= '0;
    end else begin
      drv_ctrl_axis1_o <= drv_ctrl_axis1_i;
      drv_ctrl_axis2_o <= cfg_reg.paralleled_outputs ? drv_ctrl_axis1_i : drv_ctrl_axis2_i;
    end
  end

  // ----------------------------------------------------------------
  // Shared encoder 1 pins
  // ----------------------------------------------------------------
  // Pins turn to outputs only with the compare option; otherwise they listen
  assign shared_pin_a_o = compare_pulse_out_i;
  assign shared_pin_b_o = irq_src_i;
  assign shared_pin_a_oe_o = cfg_reg.compare_irq_on_shared;
  assign shared_pin_b_oe_o = cfg_reg.compare_irq_on_shared;

  // ----------------------------------------------------------------
  // Encoder index and channel routing
  // ----------------------------------------------------------------
  logic enc1_n_next;
  logic enc2_n_next;

  // Index 1 source depends on the interface when not on the switch
  always_comb begin
    if (cfg_reg.encoder1_index_source) begin
      enc1_n_next = left_switch_axis1_i;
    end else if (interface_select_i) begin
      enc1_n_next = gp_pin_0_i;
    end else begin
      enc1_n_next = serial_line_true_i;
    end
  end

  // Index 2 mirrors index 1 on the other set of pins
  always_comb begin
    if (cfg_reg.encoder2_index_source) begin
      enc2_n_next = left_switch_axis2_i;
    end else if (interface_select_i) begin
      enc2_n_next = gp_pin_1_i;
    end else begin
      enc2_n_next = serial_line_inverted_i;
    end
  end

  // Unused encoders read A and B as zero so counters downstream stay still; the index still passes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      encoder1_o <= '0;
      encoder1_in_use_o <= 1'b0;
    end else begin
      encoder1_in_use_o <= ~cfg_reg.compare_irq_on_shared;
      if (cfg_reg.compare_irq_on_shared) begin
        encoder1_o <= '{a: 1'b0, b: 1'b0, n: enc1_n_next};
      end else begin
        encoder1_o <= '{a: shared_pin_a_i, b: shared_pin_b_i, n: enc1_n_next};
      end
    end
  end

  // Encoder 2 A/B come from the right switches when so configured
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      encoder2_o <= '0;
    end else begin
      if (cfg_reg.encoder2_on_right_refs) begin
        encoder2_o <= '{a: right_switch_axis1_i, b: right_switch_axis2_i, n: enc2_n_next};
      end else begin
        encoder2_o <= '{a: 1'b0, b: 1'b0, n: enc2_n_next};
      end
    end
  end

  // ----------------------------------------------------------------
  // Right reference switches and test output
  // ----------------------------------------------------------------
  logic right_sw_free;

  // Switches are usable only when neither encoder 2 nor test mode owns them
  assign right_sw_free = ~cfg_reg.encoder2_on_right_refs & ~cfg_reg.test_mode;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      right_switch_o <= '0;
      right_switch_valid_o <= 1'b0;
    end else begin
      right_switch_valid_o <= right_sw_free;
      right_switch_o <= right_sw_free ? {right_switch_axis2_i, right_switch_axis1_i} : '0;
    end
  end

  // Test drive on right switch 2; the host keeps this off in normal use
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      right_switch_axis2_o <= 1'b0;
      right_switch_axis2_oe_o <= 1'b0;
      test_sel_o <= '0;
    end else begin
      right_switch_axis2_oe_o <= cfg_reg.test_mode;
      right_switch_axis2_o <= cfg_reg.test_mode & test_level_i;
      test_sel_o <= cfg_reg.test_mode ? node_address_field_i : '0;
    end
  end

  // ----------------------------------------------------------------
  // Load speed coupling
  // ----------------------------------------------------------------
  logic couple_active;

  // Coupling only applies while both axes run in load speed mode
  assign couple_active = cfg_reg.load_speed_coupling & (&load_speed_mode_i);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_hold_o <= '0;
    end else begin
      load_hold_o[0] <= load_slow_i[0] | (couple_active & load_slow_i[1]);
      load_hold_o[1] <= load_slow_i[1] | (couple_active & load_slow_i[0]);
    end
  end

endmodule

/* bench/gcr_top_asserts.sv */
// Checker: access and routing assertions for the global configuration register
module gcr_top_asserts
  import gcr_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register access
  input wire logic acc_valid_i,
  input wire logic [ADDR_W-1:0] acc_addr_i,
  input wire logic [DATA_W-1:0] acc_wdata_i,
  input wire logic [DATA_W-1:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic wr_ignored_o,
  input wire logic [CFG_BITS-1:0] cfg_o,
  // Routing
  input wire logic interface_select_i,
  input wire logic uart_mode_o,
  input wire logic pulse_in_axis1_i,
  input wire logic direction_in_axis2_i,
  input wire logic [NUM_AXES-1:0] drv_pulse_o,
  input wire logic [NUM_AXES-1:0] drv_dir_o,
  input wire logic shared_pin_a_oe_o,
  input wire logic shared_pin_b_oe_o,
  input wire logic left_switch_axis1_i,
  input wire gcr_encoder_t encoder1_o
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Write aimed at the register, and the bits it would store
  logic wr_cfg;
  logic [CFG_BITS-1:0] wd_low;
  assign wr_cfg = acc_valid_i && acc_addr_i == WRITE_OFFSET;
  assign wd_low = acc_wdata_i[CFG_BITS-1:0];

  // -------------------------------------------------------------
  // Config held across the two-stage motion pipe
  // -------------------------------------------------------------
  sequence ext1_held;
    (cfg_o[POS_EXT_PULSE_CTRL_AXIS1] && !cfg_o[POS_REVERSE_AXIS1]) [*3];
  endsequence
  sequence rev2_held;
    (cfg_o[POS_EXT_PULSE_CTRL_AXIS2] && cfg_o[POS_REVERSE_AXIS2] && !cfg_o[POS_PARALLELED_OUTPUTS]) [*3];
  endsequence
  sequence par_held;
    cfg_o[POS_PARALLELED_OUTPUTS] [*3];
  endsequence

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  access_kind_a: assert property (acc_valid_i |=> rd_valid_o == !$past(acc_addr_i[WRITE_FLAG_POS]))
    else $error("read answer does not match access kind");
  read_data_a: assert property (acc_valid_i && acc_addr_i == 8'h00 |=> rd_data_o == {20'h0, $past(cfg_o)})
    else $error("read data differs from register");
  write_update_a: assert property (wr_cfg && !cfg_o[POS_WRITE_LOCK] |=> cfg_o == $past(wd_low))
    else $error("write not stored");
  lock_hold_a: assert property (wr_cfg && cfg_o[POS_WRITE_LOCK] |=> wr_ignored_o && $stable(cfg_o))
    else $error("locked register changed");
  uart_mode_a: assert property (1'b1 |=> uart_mode_o == $past(interface_select_i))
    else $error("interface mode does not follow select");
  ext_axis1_a: assert property (ext1_held |-> drv_pulse_o[0] == $past(pulse_in_axis1_i, 2))
    else $error("axis 1 pulse not from external input");
  reverse_axis2_a: assert property (rev2_held |-> drv_dir_o[1] == !$past(direction_in_axis2_i, 2))
    else $error("axis 2 direction not reversed");
  parallel_copy_a: assert property (par_held |-> drv_pulse_o[1] == drv_pulse_o[0] && drv_dir_o[1] == drv_dir_o[0])
    else $error("driver 2 differs from driver 1");
  shared_oe_a: assert property (shared_pin_a_oe_o == cfg_o[3] && shared_pin_b_oe_o == cfg_o[3])
    else $error("shared pin enable wrong");
  index1_src_a: assert property (cfg_o[POS_ENCODER1_INDEX_SOURCE] |=> encoder1_o.n == $past(left_switch_axis1_i))
    else $error("encoder 1 index not from left switch");
endmodule

bind gcr_top gcr_top_asserts i_gcr_top_asserts (
  .clk_i, .rst_n_i, .acc_valid_i, .acc_addr_i, .acc_wdata_i, .rd_data_o, .rd_valid_o, .wr_ignored_o, .cfg_o,
  .interface_select_i, .uart_mode_o, .pulse_in_axis1_i, .direction_in_axis2_i, .drv_pulse_o, .drv_dir_o,
  .shared_pin_a_oe_o, .shared_pin_b_oe_o, .left_switch_axis1_i, .encoder1_o
);

/* bench/gcr_host_model.sv */
// Host model: issues register reads and writes on the access port
module gcr_host_model
  import gcr_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Answers
  input wire logic [DATA_W-1:0] rd_data_i,
  input wire logic rd_valid_i,
  input wire logic wr_ignored_i,
  // Request
  output logic acc_valid_o,
  output logic [ADDR_W-1:0] acc_addr_o,
  output logic [DATA_W-1:0] acc_wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle bus at time zero
  initial begin
    acc_valid_o = 1'b0;
    acc_addr_o = 8'h5a;
    acc_wdata_o = 32'ha5a5_5a5a;
  end

  // Request held until the taking edge; ready is always high
  task automatic access(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
    @(posedge clk_i);
    #1;
    acc_valid_o = 1'b1;
    acc_addr_o = addr;
    acc_wdata_o = data;
    @(posedge clk_i);
    #1;
  endtask

  // Released lines show the inverse, so stale values never look live
  task automatic release_bus;
    acc_valid_o = 1'b0;
    acc_addr_o = ~acc_addr_o;
    acc_wdata_o = ~acc_wdata_o;
  endtask

  // Write: index plus offset, test bit always kept clear
  task automatic write_reg(input logic [6:0] idx, input logic [DATA_W-1:0] data, output logic ign);
    access({1'b0, idx} + WRITE_OFFSET, data & ~(32'h1 << POS_TEST_MODE));
    ign = wr_ignored_i;
    release_bus();
  endtask

  // Read: the plain index
  task automatic read_reg(input logic [6:0] idx, output logic [DATA_W-1:0] data, output logic ok);
    access({1'b0, idx}, acc_wdata_o);
    ok = rd_valid_i;
    data = rd_data_i;
    release_bus();
  endtask
endmodule

/* bench/gcr_top_tb_top.sv */
// Testbench: scenarios for the global configuration register
module gcr_top_tb_top
  import gcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic acc_valid_i, rd_valid_o, wr_ignored_o, uart_mode_o, interface_select_i, encoder1_in_use_o;
  logic [ADDR_W-1:0] acc_addr_i;
  logic [DATA_W-1:0] acc_wdata_i, rd_data_o;
  logic [CFG_BITS-1:0] cfg_o;
  logic [TEST_SEL_W-1:0] test_sel_o;
  logic acc_ready_o, right_switch_valid_o;
  logic [NUM_AXES-1:0] ramp_pulse_i, ramp_dir_i, drv_pulse_o, drv_dir_o, ramp_in_use_o, right_switch_o;
  logic [NUM_AXES-1:0] load_speed_mode_i, load_slow_i, load_hold_o;
  logic pulse_in_axis1_i, direction_in_axis1_i, pulse_in_axis2_i, direction_in_axis2_i;
  logic [DRV_CTRL_W-1:0] drv_ctrl_axis1_i, drv_ctrl_axis2_i, drv_ctrl_axis1_o, drv_ctrl_axis2_o;
  logic left_switch_axis1_i, left_switch_axis2_i, right_switch_axis1_i, right_switch_axis2_i;
  logic right_switch_axis2_o, right_switch_axis2_oe_o, r2_drive, enc_a, enc_b;
  logic serial_line_true_i, serial_line_inverted_i, gp_pin_0_i, gp_pin_1_i, compare_pulse_out_i, irq_src_i;
  logic shared_pin_a_i, shared_pin_b_i, shared_pin_a_o, shared_pin_a_oe_o, shared_pin_b_o, shared_pin_b_oe_o;
  gcr_encoder_t encoder1_o, encoder2_o;
  int n_mismatch = 0;
  int num_checks = 0;

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  // Two-way pins: the block wins while its enable is high
  assign right_switch_axis2_i = right_switch_axis2_oe_o ? right_switch_axis2_o : r2_drive;
  assign shared_pin_a_i = shared_pin_a_oe_o ? shared_pin_a_o : enc_a;
  assign shared_pin_b_i = shared_pin_b_oe_o ? shared_pin_b_o : enc_b;

  gcr_host_model i_gcr_host_model (.clk_i, .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o),
    .wr_ignored_i(wr_ignored_o), .acc_valid_o(acc_valid_i), .acc_addr_o(acc_addr_i), .acc_wdata_o(acc_wdata_i));

  gcr_top i_gcr_top (
    .clk_i, .rst_n_i, .acc_valid_i, .acc_addr_i, .acc_wdata_i, .acc_ready_o, .rd_data_o, .rd_valid_o,
    .wr_ignored_o, .cfg_o, .interface_select_i, .uart_mode_o, .ramp_pulse_i, .ramp_dir_i, .pulse_in_axis1_i,
    .direction_in_axis1_i, .pulse_in_axis2_i, .direction_in_axis2_i, .drv_ctrl_axis1_i, .drv_ctrl_axis2_i,
    .drv_pulse_o, .drv_dir_o, .drv_ctrl_axis1_o, .drv_ctrl_axis2_o, .ramp_in_use_o, .left_switch_axis1_i,
    .left_switch_axis2_i, .right_switch_axis1_i, .right_switch_axis2_i, .right_switch_axis2_o,
    .right_switch_axis2_oe_o, .serial_line_true_i, .serial_line_inverted_i, .gp_pin_0_i, .gp_pin_1_i,
    .shared_pin_a_i, .shared_pin_b_i, .shared_pin_a_o, .shared_pin_a_oe_o, .shared_pin_b_o, .shared_pin_b_oe_o,
    .compare_pulse_out_i, .irq_src_i, .node_address_field_i(3'h5), .test_level_i(1'b1), .test_sel_o,
    .encoder1_o, .encoder2_o, .encoder1_in_use_o, .right_switch_o, .right_switch_valid_o, .load_speed_mode_i,
    .load_slow_i, .load_hold_o
  );

  // -------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [11:0] v, input logic exp_ign);
    logic ign;
    i_gcr_host_model.write_reg(7'h00, {20'h0, v}, ign);
    check("write ignored", ign, exp_ign);
  endtask

  task automatic rd(input logic [6:0] idx, input logic [11:0] exp);
    logic [31:0] d;
    logic ok;
    i_gcr_host_model.read_reg(idx, d, ok);
    check("read valid", ok, 1);
    check("read data", d, {20'h0, exp});
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_reset;
    check("cfg", cfg_o, 0);
    check("ready", acc_ready_o, 1);
    rd(7'h00, 12'h000);
    rd(7'h05, 12'h000);
  endtask

  task automatic t_access;
    logic ign;
    wr(12'h36e, 1'b0);
    check("cfg", cfg_o, 12'h36e);
    rd(7'h00, 12'h36e);
    check("cfg after read", cfg_o, 12'h36e);
    i_gcr_host_model.write_reg(7'h05, 32'h0, ign);
    check("cfg other index", cfg_o, 12'h36e);
    wr(12'h000, 1'b0);
  endtask

  task automatic t_motion;
    logic [11:0] cfgs [4];
    logic [1:0] a1, a2;
    cfgs = '{12'h000, 12'h006, 12'h306, 12'h001};
    for (int i = 0; i < 4; i++) begin
      for (int k = 0; k < 2; k++) begin
        {drv_ctrl_axis1_i, drv_ctrl_axis2_i} = 16'h0;
        wr(cfgs[i], 1'b0);
        {drv_ctrl_axis1_i, drv_ctrl_axis2_i} = 16'h5aa5;
        {ramp_pulse_i, ramp_dir_i, pulse_in_axis1_i, direction_in_axis1_i, pulse_in_axis2_i,
         direction_in_axis2_i} = k ? 8'h99 : 8'h66;
        tick(3);
        a1 = cfgs[i][1] ? {pulse_in_axis1_i, direction_in_axis1_i} : {ramp_pulse_i[0], ramp_dir_i[0]};
        a2 = cfgs[i][2] ? {pulse_in_axis2_i, direction_in_axis2_i} : {ramp_pulse_i[1], ramp_dir_i[1]};
        a1[0] = a1[0] ^ cfgs[i][8];
        a2[0] = a2[0] ^ cfgs[i][9];
        if (cfgs[i][0]) a2 = a1;
        check("drv pulse", drv_pulse_o, {a2[1], a1[1]});
        check("drv dir", drv_dir_o, {a2[0], a1[0]});
        check("ramp in use", ramp_in_use_o, {~cfgs[i][2], ~cfgs[i][1]});
        check("drv ctrl 2", drv_ctrl_axis2_o, cfgs[i][0] ? 8'h5a : 8'ha5);
        check("drv ctrl 1", drv_ctrl_axis1_o, 8'h5a);
      end
    end
  endtask

  task automatic t_routing;
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 2; i++) begin
        wr(i ? 12'h078 : 12'h000, 1'b0);
        interface_select_i = s[0];
        {left_switch_axis1_i, serial_line_true_i, gp_pin_0_i} = {1'b0, !s[0], s[0]};
        {left_switch_axis2_i, serial_line_inverted_i, gp_pin_1_i} = {1'b1, s[0], !s[0]};
        {right_switch_axis1_i, r2_drive, enc_a, enc_b, compare_pulse_out_i, irq_src_i} = 6'b100110;
        tick(2);
        check("uart mode", uart_mode_o, s);
        check("encoder 1", encoder1_o, i ? 3'b000 : 3'b011);
        check("encoder 2", encoder2_o, i ? 3'b101 : 3'b000);
        check("right switches", right_switch_o, i ? 2'b00 : 2'b01);
        check("encoder 1 in use", encoder1_in_use_o, !i);
        check("right valid", right_switch_valid_o, !i);
        check("test drive", {right_switch_axis2_oe_o, right_switch_axis2_o, test_sel_o}, 5'h00);
        check("shared oe", {shared_pin_a_oe_o, shared_pin_b_oe_o}, {i[0], i[0]});
        if (i) check("shared out", {shared_pin_a_o, shared_pin_b_o}, 2'b10);
      end
    end
  endtask

  task automatic t_coupling;
    logic [6:0] tbl [3];
    logic b;
    logic [1:0] e;
    tbl = '{7'b1_11_01_11, 7'b0_11_01_01, 7'b1_01_10_10};
    for (int i = 0; i < 3; i++) begin
      {b, load_speed_mode_i, load_slow_i, e} = tbl[i];
      wr({b, 11'h0}, 1'b0);
      tick(2);
      check("load hold", load_hold_o, e);
    end
  endtask

  task automatic t_lock;
    wr(12'h402, 1'b0);
    wr(12'h000, 1'b1);
    check("cfg locked", cfg_o, 12'h402);
    rd(7'h00, 12'h402);
    rst_n_i = 1'b0;
    tick(2);
    rst_n_i = 1'b1;
    tick(1);
    check("cfg after reset", cfg_o, 0);
    wr(12'h002, 1'b0);
    check("cfg unlocked", cfg_o, 12'h002);
  endtask

  // Main sequence: reset, then every scenario in turn
  initial begin
    {interface_select_i, ramp_pulse_i, ramp_dir_i, pulse_in_axis1_i, direction_in_axis1_i, pulse_in_axis2_i,
     direction_in_axis2_i, drv_ctrl_axis1_i, drv_ctrl_axis2_i, left_switch_axis1_i, left_switch_axis2_i,
     right_switch_axis1_i, r2_drive, serial_line_true_i, serial_line_inverted_i, gp_pin_0_i, gp_pin_1_i,
     enc_a, enc_b, compare_pulse_out_i, irq_src_i, load_speed_mode_i, load_slow_i} = '0;
    tick(5);
    rst_n_i = 1'b1;
    t_reset();
    t_access();
    t_motion();
    t_routing();
    t_coupling();
    t_lock();
    report_and_stop();
  end

  // Watchdog: the run needs under a hundred cycles, 10000 means a hang
  initial begin
    #50000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
